// ==== bench/secondary_reset_and_pme_logic_tb.sv ====
// self-checking bench of the secondary reset and power event logic
`timescale 1ns/10ps
module secondary_reset_and_pme_logic_tb;
  // ==========================================
  // stimulus and design
  localparam int RC = 3;
  logic ref_clk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic prim_n = 1'h0;
  logic strap = 1'h1;
  logic sec_bit = 1'h0, chip = 1'h0, pwr = 1'h0, pme_en = 1'h0, st_ok = 1'h0;
  logic pme_clr = 1'h0, int_en = 1'h0, int_clr = 1'h0, ev_req = 1'h0;
  logic subsys_n, bus_oe, cfg_ok, pme_n, pme_oe, inta_n, inta_oe, sec_rst_n;
  logic pme_st, int_pend, central, exp_cen, exp_st;
  rst_pme_pkg::sec_drive_t drv;
  rst_pme_pkg::reset_cause_t cause;
  logic [31:0] seed = 32'h0d5067d7;
  int n_mismatch = 0;
  int compares = 0;
  always #4 ref_clk_i = ~ref_clk_i;
  subsys_model partner (.event_req_i(ev_req), .subsys_pme_n_o(subsys_n));
  secondary_reset_and_pme_logic #(.RELEASE_CYCLES(RC)) dut (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .primary_reset_n_i(prim_n),
    .central_resource_strap_i(strap), .sec_reset_bit_i(sec_bit),
    .chip_reset_set_i(chip), .pm_d3hot_to_d0_i(pwr), .pme_en_i(pme_en),
    .pme_state_ok_i(st_ok), .pme_status_clear_i(pme_clr), .status_int_en_i(int_en),
    .status_int_clear_i(int_clr), .subsys_pme_n_i(subsys_n),
    .primary_bus_oe_o(bus_oe), .config_access_ok_o(cfg_ok), .primary_pme_n_o(pme_n),
    .primary_pme_oe_o(pme_oe), .primary_inta_n_o(inta_n), .primary_inta_oe_o(inta_oe),
    .secondary_reset_n_o(sec_rst_n), .sec_drive_o(drv), .pme_status_o(pme_st),
    .status_int_pending_o(int_pend), .central_resource_o(central),
    .reset_cause_o(cause));
  // ==========================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic rst_pme_pkg::sec_drive_t sd_exp(input logic act, input logic cen);
    return '{~act, 1'h0, act & cen, act & cen};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ==========================================
  // secondary reset causes: 0 level bit, 1 chip pulse, 2 power pulse
  task automatic sec_test(input int k);
    int n;
    n = 0;
    if (k == 0) begin
      sec_bit = 1'h1;
      #1;
      chk(sec_rst_n, 1'h0);
      chk(cause, 4'h4);
      chk(drv, sd_exp(1'h1, exp_cen));
      chk(cfg_ok, 1'h1);
      tick(RC + 2);
      chk(sec_rst_n, 1'h0);
      sec_bit = 1'h0;
      #1;
      chk(sec_rst_n, 1'h1);
    end else begin
      chip = (k == 1);
      pwr = (k == 2);
      tick(1);
      chip = 1'h0;
      pwr = 1'h0;
      chk(sec_rst_n, 1'h0);
      chk(cause, (k == 1) ? 4'h2 : 4'h1);
      chk(drv, sd_exp(1'h1, exp_cen));
      tick(1);
      chip = (k == 1);
      pwr = (k == 2);
      tick(1);
      chip = 1'h0;
      pwr = 1'h0;
      while (sec_rst_n === 1'h0 && n < 20) begin
        n++;
        tick(1);
      end
      chk(n[7:0], 8'(RC));
    end
    chk(drv, sd_exp(1'h0, exp_cen));
    chk(pme_st, exp_st);
    chk(central, exp_cen);
    tick(1);
    $display("secondary reset test %0d done", k);
  endtask
  task automatic set_status;
    ev_req = 1'h1;
    tick(2);
    ev_req = 1'h0;
    tick(2);
    exp_st = 1'h1;
  endtask
  // ==========================================
  // main sequence
  initial begin
    exp_cen = 1'h0;
    exp_st = 1'h0;
    tick(8);
    rst_n_i = 1'h1;
    prim_n = 1'h1;
    tick(1);
    chk(central, exp_cen);
    set_status();
    for (int k = 0; k < 3; k++) begin
      sec_test(k);
    end
    // wake tests start from cleared flags
    pme_clr = 1'h1;
    int_clr = 1'h1;
    tick(1);
    pme_clr = 1'h0;
    int_clr = 1'h0;
    chk(pme_st, 1'h0);
    chk(int_pend, 1'h0);
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      pme_en = seed[0] | (i == 0);
      st_ok = seed[1] | (i == 0);
      int_en = seed[2] | (i == 0);
      ev_req = 1'h1;
      tick(2);
      chk(pme_st, 1'h1);
      chk(pme_oe, pme_en & st_ok);
      chk(pme_n, 1'h0);
      ev_req = 1'h0;
      tick(2);
      chk(int_pend, 1'h1);
      chk(inta_oe, int_en);
      chk(inta_n, 1'h0);
      if (seed[3]) begin
        pme_clr = 1'h1;
        tick(1);
        pme_clr = 1'h0;
        chk(pme_st, 1'h0);
      end else begin
        pme_en = 1'h0;
        tick(1);
        chk(pme_oe, 1'h0);
        pme_clr = 1'h1;
        tick(1);
        pme_clr = 1'h0;
      end
      chk(pme_oe, 1'h0);
      int_clr = 1'h1;
      tick(1);
      int_clr = 1'h0;
      chk(int_pend, 1'h0);
      chk(inta_oe, 1'h0);
      $display("wake test %0d done", i);
    end
    // event edge and status clear in one cycle: the edge wins
    ev_req = 1'h1;
    pme_clr = 1'h1;
    tick(1);
    pme_clr = 1'h0;
    chk(pme_st, 1'h1);
    ev_req = 1'h0;
    tick(2);
    chk(int_pend, 1'h1);
    $display("set against clear test done");
    for (int i = 0; i < 2; i++) begin
      pme_en = 1'h1;
      st_ok = 1'h1;
      set_status();
      strap = i[0];
      exp_cen = ~strap;
      @(posedge ref_clk_i);
      #3;
      prim_n = 1'h0;
      #1;
      chk(sec_rst_n, 1'h0);
      chk(cause[3], 1'h1);
      chk(bus_oe, 1'h0);
      chk(cfg_ok, 1'h0);
      chk(drv.ctrl_oe, 1'h0);
      chk(pme_st, 1'h0);
      chk(pme_oe, 1'h0);
      chk(int_pend, 1'h0);
      tick(3);
      prim_n = 1'h1;
      exp_st = 1'h0;
      tick(1);
      chk(sec_rst_n, 1'h1);
      chk(bus_oe, 1'h1);
      chk(central, exp_cen);
      strap = ~strap;
      sec_test(0);
      $display("primary reset test %0d done", i);
    end
    close_out();
  end
  // ==========================================
  // watchdog
  initial begin
    #100000;
    n_mismatch++;
    close_out();
  end
endmodule

// ==== bench/subsys_model.sv ====
// subsystem model that drives the event line
`timescale 1ns/10ps
module subsys_model (
  // request from the bench
  input wire logic event_req_i,
  // event line, pulled up while released
  output logic subsys_pme_n_o
);
  // ==========================================
  // line drive
  assign subsys_pme_n_o = event_req_i ? 1'h0 : 1'h1;
endmodule

// ==== logic/level_edge_detect.sv ====
// edge detector for a synchronous level input
`timescale 1ns/10ps
`include "rst_pme_params.svh"
module level_edge_detect (
  // clock and resets
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic primary_reset_n_i,
  // level in, edges out
  input wire logic level_i,
  output logic fall_o,
  output logic rise_o
);
  logic prev_ff;
  logic nxt_prev;

  // ==========================================================
  // previous level
  always_comb begin
    nxt_prev = rst_n_i ? level_i : `SUBSYS_EVENT_IDLE;
  end

  always_ff @(posedge ref_clk_i or negedge primary_reset_n_i) begin
    if (!primary_reset_n_i) begin
      prev_ff <= `SUBSYS_EVENT_IDLE;
    end else begin
      prev_ff <= nxt_prev;
    end
  end

  assign fall_o = prev_ff & ~level_i;
  assign rise_o = ~prev_ff & level_i;
endmodule

// ==== logic/release_timer.sv ====
// one-shot timer that holds busy for a fixed number of cycles
`timescale 1ns/10ps
`include "rst_pme_params.svh"
module release_timer #(
  parameter int CYCLES = `SEC_RELEASE_CYCLES
) (
  // clock and resets
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic primary_reset_n_i,
  // start and busy
  input wire logic start_i,
  output logic busy_o
);
  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LOAD = W'(CYCLES - 1);
  localparam logic [W-1:0] ONE = W'(1);

  generate
    if (CYCLES < 1) begin : g_bad_cycles
      $error("release_timer: CYCLES must be at least 1");
    end
  endgenerate

  rst_pme_pkg::tmr_state_t state_ff;
  rst_pme_pkg::tmr_state_t nxt_state;
  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  // ==========================================================
  // countdown
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      rst_pme_pkg::tmr_idle: begin
        if (start_i) begin
          nxt_state = rst_pme_pkg::tmr_count;
          nxt_cnt = LOAD;
        end
      end
      rst_pme_pkg::tmr_count: begin
        if (start_i) begin
          nxt_cnt = LOAD; // see (R12)
        end else if (cnt_ff == '0) begin
          nxt_state = rst_pme_pkg::tmr_idle; // see (R12)
        end else begin
          nxt_cnt = cnt_ff - ONE;
        end
      end
      default: begin
        nxt_state = rst_pme_pkg::tmr_idle;
        nxt_cnt = '0;
      end
    endcase
    if (!rst_n_i) begin
      nxt_state = rst_pme_pkg::tmr_idle;
      nxt_cnt = '0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge primary_reset_n_i) begin
    if (!primary_reset_n_i) begin
      state_ff <= rst_pme_pkg::tmr_idle;
      cnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  assign busy_o = (state_ff == rst_pme_pkg::tmr_count);

  // ==========================================================
  // checks
  a_timer_start: assert property (@(posedge ref_clk_i) // see (R12)
    disable iff (!primary_reset_n_i || !rst_n_i) start_i |=> busy_o)
    else $error("timer did not start");
  a_timer_end: assert property (@(posedge ref_clk_i) // see (R18)
    disable iff (!primary_reset_n_i || !rst_n_i)
    busy_o && cnt_ff == '0 && !start_i |=> !busy_o)
    else $error("timer did not expire");
endmodule

// ==== logic/rst_pme_params.svh ====
// constants of the secondary reset and power event logic
`ifndef RST_PME_PARAMS_SVH
`define RST_PME_PARAMS_SVH
`define CLK_PERIOD_NS 8
`define SEC_RELEASE_TIME_NS 1000
`define SEC_RELEASE_CYCLES ((`SEC_RELEASE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SUBSYS_EVENT_IDLE 1'h1
`define STRAP_DEFAULT 1'h1
`define STATUS_CLEAR 1'h0
`define PIN_LOW 1'h0
`endif

// ==== logic/rst_pme_pkg.sv ====
// types of the secondary reset and power event logic
package rst_pme_pkg;
  typedef enum {tmr_idle, tmr_count} tmr_state_t;
  typedef struct packed {
    logic ctrl_oe;
    logic secondary_wide_request_n;
    logic wide_request_oe;
    logic zero_drive_oe;
  } sec_drive_t;
  typedef struct packed {
    logic primary;
    logic sec_bit;
    logic chip;
    logic power;
  } reset_cause_t;
endpackage

// ==== logic/secondary_reset_and_pme_logic.sv ====
// secondary reset, bus drive state and power event logic of the bridge
//
// Contract
// (R01) primary reset clears every register; prev_ff instead loads the idle level 1, strap_ff loads central_resource_strap_i
// (R02) primary reset floats bus outputs, few exceptions
// (R03) primary reset asserts without a clock
// (R04) falling subsystem event edge may raise wake
// (R05) rising subsystem event edge may raise interrupt
// (R06) any reset cause asserts secondary reset
// (R07) secondary or chip reset bit asserts it
// (R08) D3hot to D0 transition asserts it
// (R09) secondary reset floats secondary control outputs
// (R10) central resource drives zeros, wide request
// (R11) untimed causes hold until primary, bit clear
// (R12) chip and power causes release by timer
// (R13) secondary reset leaves registers unchanged
// (R14) config access stays open during secondary reset
// (R15) wake needs event, state support and enable
// (R16) clearing status or enable drops wake
// (R17) central resource strap captured during primary reset
// (R18) release timer length is a parameter
`timescale 1ns/10ps
`include "rst_pme_params.svh"
module secondary_reset_and_pme_logic #(
  parameter int RELEASE_CYCLES = `SEC_RELEASE_CYCLES
) (
  // clock and resets
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic primary_reset_n_i,
  // strap
  input wire logic central_resource_strap_i,
  // software control bits
  input wire logic sec_reset_bit_i,
  input wire logic chip_reset_set_i,
  input wire logic pm_d3hot_to_d0_i,
  input wire logic pme_en_i,
  input wire logic pme_state_ok_i,
  input wire logic pme_status_clear_i,
  input wire logic status_int_en_i,
  input wire logic status_int_clear_i,
  // subsystem
  input wire logic subsys_pme_n_i,
  // primary side
  output logic primary_bus_oe_o,
  output logic config_access_ok_o,
  output logic primary_pme_n_o,
  output logic primary_pme_oe_o,
  output logic primary_inta_n_o,
  output logic primary_inta_oe_o,
  // secondary side
  output logic secondary_reset_n_o,
  output rst_pme_pkg::sec_drive_t sec_drive_o,
  // status
  output logic pme_status_o,
  output logic status_int_pending_o,
  output logic central_resource_o,
  output rst_pme_pkg::reset_cause_t reset_cause_o
);
  generate
    if (RELEASE_CYCLES < 1) begin : g_bad_release
      $error("RELEASE_CYCLES must be at least 1");
    end
  endgenerate

  logic ev_fall;
  logic ev_rise;
  logic chip_busy;
  logic pm_busy;
  logic sec_active;
  logic central;
  logic strap_ff;
  logic nxt_strap;
  logic pme_status_ff;
  logic nxt_pme_status;
  logic int_status_ff;
  logic nxt_int_status;

  // ==========================================================
  // subsystem event edges
  level_edge_detect u_event_edges (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .primary_reset_n_i(primary_reset_n_i),
    .level_i(subsys_pme_n_i),
    .fall_o(ev_fall),
    .rise_o(ev_rise)
  );

  // ==========================================================
  // timed release causes
  release_timer #(
    .CYCLES(RELEASE_CYCLES) // see (R18)
  ) u_chip_timer (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .primary_reset_n_i(primary_reset_n_i),
    .start_i(chip_reset_set_i), // see (R07)
    .busy_o(chip_busy)
  );

  release_timer #(
    .CYCLES(RELEASE_CYCLES) // see (R18)
  ) u_pm_timer (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .primary_reset_n_i(primary_reset_n_i),
    .start_i(pm_d3hot_to_d0_i), // see (R08)
    .busy_o(pm_busy)
  );

  // ==========================================================
  // strap capture
  always_comb begin
    nxt_strap = strap_ff;
    if (!primary_reset_n_i) begin
      nxt_strap = central_resource_strap_i; // see (R17)
    end else if (!rst_n_i) begin
      nxt_strap = `STRAP_DEFAULT;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    strap_ff <= nxt_strap;
  end

  assign central = ~strap_ff; // see (R17)

  // ==========================================================
  // event status flags
  always_comb begin
    nxt_pme_status = pme_status_ff & ~pme_status_clear_i; // see (R16)
    if (ev_fall) begin
      nxt_pme_status = 1'h1; // see (R04)
    end
    nxt_int_status = int_status_ff & ~status_int_clear_i;
    if (ev_rise) begin
      nxt_int_status = 1'h1; // see (R05)
    end
    if (!rst_n_i) begin
      nxt_pme_status = `STATUS_CLEAR;
      nxt_int_status = `STATUS_CLEAR;
    end
  end

  // secondary reset leaves these alone; primary reset, rst_n_i and the clear inputs clear them; see (R13)
  always_ff @(posedge ref_clk_i or negedge primary_reset_n_i) begin
    if (!primary_reset_n_i) begin
      pme_status_ff <= `STATUS_CLEAR; // see (R01) see (R03)
      int_status_ff <= `STATUS_CLEAR; // see (R01)
    end else begin
      pme_status_ff <= nxt_pme_status;
      int_status_ff <= nxt_int_status;
    end
  end

  // ==========================================================
  // secondary reset and drive state
  assign sec_active = ~primary_reset_n_i // see (R03) see (R06) see (R11)
    | sec_reset_bit_i // see (R07) see (R11)
    | chip_busy // see (R12)
    | pm_busy; // see (R08) see (R12)

  assign secondary_reset_n_o = ~sec_active; // see (R06)

  always_comb begin
    sec_drive_o.ctrl_oe = ~sec_active; // see (R09)
    sec_drive_o.secondary_wide_request_n = `PIN_LOW; // see (R10)
    sec_drive_o.wide_request_oe = sec_active & central; // see (R10)
    sec_drive_o.zero_drive_oe = sec_active & central; // see (R10)
  end

  // ==========================================================
  // primary side outputs
  assign primary_bus_oe_o = primary_reset_n_i; // see (R02)
  assign config_access_ok_o = primary_reset_n_i; // see (R14)
  assign primary_pme_n_o = `PIN_LOW;
  assign primary_pme_oe_o = pme_status_ff & pme_en_i & pme_state_ok_i; // see (R15) see (R16)
  assign primary_inta_n_o = `PIN_LOW;
  assign primary_inta_oe_o = int_status_ff & status_int_en_i; // see (R05)

  assign pme_status_o = pme_status_ff;
  assign status_int_pending_o = int_status_ff;
  assign central_resource_o = central;

  always_comb begin
    reset_cause_o.primary = ~primary_reset_n_i;
    reset_cause_o.sec_bit = sec_reset_bit_i;
    reset_cause_o.chip = chip_busy;
    reset_cause_o.power = pm_busy;
  end

  // ==========================================================
  // checks
  a_regs_cleared: assert property (@(posedge ref_clk_i) // see (R01)
    disable iff (!rst_n_i)
    $rose(primary_reset_n_i) |-> !pme_status_o && !status_int_pending_o
      && !reset_cause_o.chip && !reset_cause_o.power)
    else $error("registers not cleared by primary reset");

  a_bus_floated: assert property (@(posedge ref_clk_i) // see (R02)
    disable iff (!rst_n_i)
    !primary_reset_n_i |-> !primary_bus_oe_o && !sec_drive_o.ctrl_oe
      && !primary_pme_oe_o && !primary_inta_oe_o)
    else $error("bus driven during primary reset");

  a_async_assert: assert property (@(posedge ref_clk_i) // see (R03)
    disable iff (!rst_n_i)
    !primary_reset_n_i |-> !secondary_reset_n_o && !config_access_ok_o)
    else $error("primary reset not passed through");

  a_wake_edge: assert property (@(posedge ref_clk_i) // see (R04)
    disable iff (!primary_reset_n_i || !rst_n_i)
    $fell(subsys_pme_n_i) ##1 (pme_en_i && pme_state_ok_i) |-> primary_pme_oe_o)
    else $error("wake not raised on event edge");

  a_status_edge: assert property (@(posedge ref_clk_i) // see (R05)
    disable iff (!primary_reset_n_i || !rst_n_i)
    $rose(subsys_pme_n_i) |=> status_int_pending_o)
    else $error("status edge not caught");

  a_sec_bit: assert property (@(posedge ref_clk_i) // see (R06) see (R07)
    disable iff (!primary_reset_n_i || !rst_n_i)
    sec_reset_bit_i |-> !secondary_reset_n_o)
    else $error("secondary reset bit ignored");

  a_chip_reset: assert property (@(posedge ref_clk_i) // see (R07)
    disable iff (!primary_reset_n_i || !rst_n_i)
    chip_reset_set_i |=> !secondary_reset_n_o && reset_cause_o.chip)
    else $error("chip reset did not assert secondary reset");

  a_power_reset: assert property (@(posedge ref_clk_i) // see (R08)
    disable iff (!primary_reset_n_i || !rst_n_i)
    pm_d3hot_to_d0_i |=> !secondary_reset_n_o ##0 reset_cause_o.power)
    else $error("power transition did not assert secondary reset");

  a_ctrl_hiz: assert property (@(posedge ref_clk_i) // see (R09)
    !secondary_reset_n_o |-> !sec_drive_o.ctrl_oe)
    else $error("control outputs driven in secondary reset");

  a_central_drive: assert property (@(posedge ref_clk_i) // see (R10)
    disable iff (!rst_n_i)
    !secondary_reset_n_o && central_resource_o |-> sec_drive_o.zero_drive_oe
      && sec_drive_o.wide_request_oe && !sec_drive_o.secondary_wide_request_n)
    else $error("central resource not driving in reset");

  a_noncentral_hiz: assert property (@(posedge ref_clk_i) // see (R10)
    disable iff (!rst_n_i)
    !central_resource_o |-> !sec_drive_o.zero_drive_oe && !sec_drive_o.wide_request_oe)
    else $error("non-central bridge driving secondary lines");

  a_hold_release: assert property (@(posedge ref_clk_i) // see (R11)
    disable iff (!primary_reset_n_i || !rst_n_i)
    $fell(sec_reset_bit_i) && !chip_busy && !pm_busy |-> secondary_reset_n_o)
    else $error("secondary reset held after causes ended");

  a_timed_release: assert property (@(posedge ref_clk_i) // see (R12)
    disable iff (!primary_reset_n_i || !rst_n_i)
    $fell(chip_busy) && !pm_busy && !sec_reset_bit_i |-> secondary_reset_n_o)
    else $error("timed cause not released");

  a_regs_kept: assert property (@(posedge ref_clk_i) // see (R13)
    disable iff (!primary_reset_n_i || !rst_n_i)
    !secondary_reset_n_o && pme_status_o && !pme_status_clear_i |=> pme_status_o)
    else $error("secondary reset disturbed register state");

  a_config_open: assert property (@(posedge ref_clk_i) // see (R14)
    disable iff (!primary_reset_n_i)
    !secondary_reset_n_o |-> config_access_ok_o)
    else $error("config access closed in secondary reset");

  a_wake_gate: assert property (@(posedge ref_clk_i) // see (R15)
    primary_pme_oe_o |-> pme_status_o && pme_en_i && pme_state_ok_i)
    else $error("wake asserted without all conditions");

  a_int_gate: assert property (@(posedge ref_clk_i) // see (R05)
    primary_inta_oe_o |-> status_int_pending_o && status_int_en_i)
    else $error("interrupt asserted without flag and enable");

  a_wake_release: assert property (@(posedge ref_clk_i) // see (R16)
    disable iff (!primary_reset_n_i || !rst_n_i)
    pme_status_clear_i && !$fell(subsys_pme_n_i) |=> !primary_pme_oe_o)
    else $error("wake not released after status clear");

  a_strap_capture: assert property (@(posedge ref_clk_i) // see (R17)
    disable iff (!rst_n_i)
    !primary_reset_n_i |=> central_resource_o == !$past(central_resource_strap_i))
    else $error("strap not captured during primary reset");

  c_chip_cycle: cover property (@(posedge ref_clk_i)
    disable iff (!primary_reset_n_i || !rst_n_i)
    chip_reset_set_i ##1 !secondary_reset_n_o ##[1:1000] secondary_reset_n_o);
  c_power_cycle: cover property (@(posedge ref_clk_i)
    disable iff (!primary_reset_n_i || !rst_n_i)
    pm_d3hot_to_d0_i ##1 !secondary_reset_n_o ##[1:1000] secondary_reset_n_o);
  c_wake: cover property (@(posedge ref_clk_i)
    disable iff (!primary_reset_n_i || !rst_n_i)
    primary_pme_oe_o ##[1:50] !primary_pme_oe_o);
  c_status_int: cover property (@(posedge ref_clk_i)
    disable iff (!primary_reset_n_i || !rst_n_i)
    primary_inta_oe_o);
  c_central: cover property (@(posedge ref_clk_i)
    sec_drive_o.zero_drive_oe);
endmodule
